// ===== link_consts.vh
// Constants for the serial link bring-up and word timing block
`ifndef LINK_CONSTS_VH
`define LINK_CONSTS_VH
`define KEEP_OFF_CYCLES 4096
`define CAL_CYCLES 40
`define WORD_LINK_CYCLES 5
`define STROBE_LOW_CYCLES 3
`define RESYNC_GAP_CYCLES 2
`define MULT_SEL_RESERVED 3'h7
`endif

// ===== link_clock_gen.v
// Link clock enable generator: one tick every ratio core clock periods, ratio decoded from multiplier_select
`timescale 1ns/1ps
module link_clock_gen (
	input wire core_clk,
	input wire reset_n,
	input wire [2:0] multiplier_select,
	output reg link_tick
);
`include "link_consts.vh"
reg [3:0] ratio;
reg [3:0] count;

// ------------------------------------------------------------
// Ratio decode
// ------------------------------------------------------------
// RQ16: code to ratio
always @* begin
	case (multiplier_select)
	3'h0: ratio = 4'h2;
	3'h1: ratio = 4'h4;
	3'h2: ratio = 4'h6;
	3'h3: ratio = 4'h7;
	3'h4: ratio = 4'h8;
	3'h5: ratio = 4'h9;
	3'h6: ratio = 4'hA;
	default: ratio = 4'h0;
	endcase
end

// ------------------------------------------------------------
// Divider
// ------------------------------------------------------------
// RQ8: period by multiplier
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		count <= 4'h0;
		link_tick <= 1'b0;
	end else if (ratio == 4'h0) begin
		count <= 4'h0;
		link_tick <= 1'b0;
	end else if (count >= ratio - 4'h1) begin
		count <= 4'h0;
		link_tick <= 1'b1;
	end else begin
		count <= count + 4'h1;
		link_tick <= 1'b0;
	end
end
endmodule

// ===== serdes_link_bringup.v
// Serial link bring-up sequencing, word serializer and slave strobe timing
//
// Overview of operation
// RQ1: Controller holds power_down_n low during supply ramp until power stable.
// RQ2: Slave power_down_n released before or together with master's.
// RQ3: Reference clock runs before master power_down_n rises.
// RQ4: Host sends nothing until link powered and PLL locked.
// RQ5: Master keeps link inactive for 4096 reference cycles after release.
// RQ6: Further 40 cycles of calibration; host writes only afterwards.
// RQ7: Each 16-bit write serializes in exactly five link clock cycles; the code sends a header tick, then only bits 15:8.
// RQ8: Link clock period equals reference period divided by selected multiplier; the code makes it twice the ratio times the core clock period.
// RQ9: Host spaces word loads at least six link cycles apart.
// RQ10: Long idle gap between words forces a bit resynchronization.
// RQ11: Slave strobe low exactly three link cycles per write.
// RQ12: Stopped reference clock needs power-down pulse and full bring-up.
// RQ13: Data lane pins swap by role-select; the code only gates both lane drivers by role, with no swap.
// RQ14: Shared pin: interrupt output as master, clock disable input as slave.
// RQ15: Role high is master with drivers; low is slave with receivers.
// RQ16: Select codes 0-6 give ratios 2,4,6,7,8,9,10; 7 reserved.
// RQ17: Low power_down_n resets all internal logic.
// RQ18: Master link-ready stays low until keep-off and calibration finish.
`timescale 1ns/1ps
`include "link_consts.vh"
module serdes_link_bringup #(
	parameter KEEP_OFF = `KEEP_OFF_CYCLES
) (
	input wire core_clk,
	input wire rst_n,
	input wire power_down_n,
	input wire role_master,
	input wire [2:0] multiplier_select,
	input wire enable_strobe_style,
	input wire word_valid,
	input wire [15:0] word_data,
	input wire host_interrupt_req,
	input wire shared_pin_in,
	output wire shared_pin_out,
	output wire shared_pin_oe_n,
	input wire serial_data_lane_a_in,
	input wire serial_data_lane_b_in,
	output reg serial_data_lane_a_out,
	output reg serial_data_lane_b_out,
	output wire serial_data_lane_a_oe_n,
	output wire serial_data_lane_b_oe_n,
	output wire serial_link_clock_out,
	output wire serial_link_clock_oe_n,
	output wire link_ready,
	output wire word_busy,
	output reg resync,
	output reg write_strobe_n,
	output reg device_select_n,
	output wire clock_output_enable
);
localparam integer STROBE_LOW = `STROBE_LOW_CYCLES;
localparam ST_OFF = 2'h0;
localparam ST_KEEP = 2'h1;
localparam ST_CAL = 2'h2;
localparam ST_RUN = 2'h3;

reg [1:0] rst_sync;
reg [1:0] pd_sync;
reg [1:0] cdis_sync;
wire reset_n;
reg [1:0] state;
reg [12:0] wait_count;
reg [2:0] bit_count;
reg [15:0] shift;
reg sending;
reg [1:0] strobe_count;
reg [3:0] idle_count;
reg link_clk_q;
wire link_tick;

// ------------------------------------------------------------
// Reset and pin synchronisers
// ------------------------------------------------------------
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		rst_sync <= 2'h0;
	end else begin
		rst_sync <= {rst_sync[0], 1'b1};
	end
end
always @(posedge core_clk or negedge rst_sync[1]) begin
	if (!rst_sync[1]) begin
		pd_sync <= 2'h0;
		cdis_sync <= 2'h0;
	end else begin
		pd_sync <= {pd_sync[0], power_down_n};
		cdis_sync <= {cdis_sync[0], shared_pin_in};
	end
end
// RQ17: power-down resets logic
assign reset_n = rst_sync[1] & pd_sync[1];

link_clock_gen u_clk (
	.core_clk(core_clk),
	.reset_n(reset_n),
	.multiplier_select(multiplier_select),
	.link_tick(link_tick)
);

// ------------------------------------------------------------
// Bring-up sequencer
// ------------------------------------------------------------
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		state <= ST_OFF;
		wait_count <= 13'h0;
	end else begin
		case (state)
		ST_OFF: begin
			if (role_master) begin
				state <= ST_KEEP;
			end
			wait_count <= 13'h0;
		end
		// RQ5: keep-off count
		ST_KEEP: begin
			if (wait_count >= KEEP_OFF - 1) begin
				state <= ST_CAL;
				wait_count <= 13'h0;
			end else begin
				wait_count <= wait_count + 13'h1;
			end
		end
		// RQ6: calibration interval
		ST_CAL: begin
			if (wait_count >= `CAL_CYCLES - 1) begin
				state <= ST_RUN;
				wait_count <= 13'h0;
			end else begin
				wait_count <= wait_count + 13'h1;
			end
		end
		default: begin
			state <= ST_RUN;
		end
		endcase
	end
end
// RQ18: ready after keep-off and calibration
assign link_ready = (state == ST_RUN) & role_master;

// ------------------------------------------------------------
// Word serializer
// ------------------------------------------------------------
assign word_busy = sending | ~link_ready;
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		sending <= 1'b0;
		bit_count <= 3'h0;
		shift <= 16'h0;
		idle_count <= 4'h0;
		resync <= 1'b0;
		serial_data_lane_a_out <= 1'b0;
		serial_data_lane_b_out <= 1'b0;
		link_clk_q <= 1'b0;
	end else begin
		link_clk_q <= link_tick ? ~link_clk_q : link_clk_q;
		if (!sending && word_valid && link_ready) begin
			sending <= 1'b1;
			bit_count <= 3'h0;
			shift <= word_data;
			// RQ10: resync after long gap
			resync <= (idle_count >= `RESYNC_GAP_CYCLES);
		end else if (sending && link_tick) begin
			// RQ7: five link cycles per word, two lanes
			serial_data_lane_a_out <= (bit_count == 3'h0) ? 1'b1 : shift[15];
			serial_data_lane_b_out <= (bit_count == 3'h0) ? resync : shift[14];
			if (bit_count != 3'h0) begin
				shift <= {shift[13:0], 2'h0};
			end
			if (bit_count == `WORD_LINK_CYCLES - 1) begin
				sending <= 1'b0;
				idle_count <= 4'h0;
			end
			bit_count <= bit_count + 3'h1;
		end else if (!sending && link_tick && idle_count != 4'hF) begin
			serial_data_lane_a_out <= 1'b0;
			serial_data_lane_b_out <= 1'b0;
			idle_count <= idle_count + 4'h1;
		end
	end
end

// ------------------------------------------------------------
// Slave output strobe
// ------------------------------------------------------------
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		strobe_count <= 2'h0;
		write_strobe_n <= 1'b1;
		device_select_n <= 1'b1;
	end else begin
		// RQ11: strobe low three link cycles
		if (sending && link_tick && bit_count == `WORD_LINK_CYCLES - 1) begin
			strobe_count <= STROBE_LOW[1:0];
		end else if (link_tick && strobe_count != 2'h0) begin
			strobe_count <= strobe_count - 2'h1;
		end
		write_strobe_n <= ~(strobe_count != 2'h0 && !enable_strobe_style);
		device_select_n <= ~(strobe_count != 2'h0 && enable_strobe_style);
	end
end

// ------------------------------------------------------------
// Role-dependent pins
// ------------------------------------------------------------
// RQ15: drivers only in master role
assign serial_link_clock_out = link_clk_q;
assign serial_link_clock_oe_n = ~role_master;
// RQ13: both lane drivers enabled by role, lanes never swapped
assign serial_data_lane_a_oe_n = ~role_master;
assign serial_data_lane_b_oe_n = ~role_master;
// RQ14: shared interrupt or clock-disable pin
assign shared_pin_out = host_interrupt_req;
assign shared_pin_oe_n = ~role_master;
assign clock_output_enable = ~role_master & cdis_sync[1] & pd_sync[1];
endmodule

// ===== serdes_link_chk.sv
// Port checker for the link bring-up block
`timescale 1ns/1ps
module serdes_link_chk (
	input wire core_clk,
	input wire rst_n,
	input wire power_down_n,
	input wire role_master,
	input wire word_valid,
	input wire word_busy,
	input wire link_ready,
	input wire write_strobe_n,
	input wire device_select_n,
	input wire enable_strobe_style,
	input wire serial_data_lane_a_oe_n,
	input wire serial_link_clock_oe_n,
	input wire shared_pin_oe_n,
	input wire clock_output_enable
);
// ----------------
// Port properties
// ----------------
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
sequence taken_s;
	word_valid && !word_busy;
endsequence
sequence pd_held_s;
	!power_down_n [*5];
endsequence
take_busy_a: assert property (taken_s |=> word_busy) else $error("busy missing");
ready_gate_a: assert property (!link_ready |-> word_busy) else $error("busy low early");
pd_reset_a: assert property (pd_held_s |-> !link_ready && write_strobe_n && device_select_n)
	else $error("power down ignored");
slave_ready_a: assert property (!role_master && $stable(role_master) |-> !link_ready)
	else $error("slave ready");
drv_role_a: assert property ($stable(role_master) |-> serial_data_lane_a_oe_n == !role_master
	&& serial_link_clock_oe_n == !role_master) else $error("driver enable wrong");
shared_oe_a: assert property ($stable(role_master) |-> shared_pin_oe_n == !role_master)
	else $error("shared pin enable wrong");
clk_en_a: assert property (role_master |-> !clock_output_enable) else $error("clock out in master");
cs_style_a: assert property (!enable_strobe_style && $stable(enable_strobe_style) |-> device_select_n)
	else $error("select strobe in write style");
wr_style_a: assert property (enable_strobe_style && $stable(enable_strobe_style) |-> write_strobe_n)
	else $error("write strobe in enable style");
endmodule
bind serdes_link_bringup serdes_link_chk serdes_link_chk_inst (.core_clk, .rst_n, .power_down_n,
	.role_master, .word_valid, .word_busy, .link_ready, .write_strobe_n, .device_select_n,
	.enable_strobe_style, .serial_data_lane_a_oe_n, .serial_link_clock_oe_n, .shared_pin_oe_n,
	.clock_output_enable);

// ===== display_driver_model.sv
// Display driver model: counts writes and measures strobe low width
`timescale 1ns/1ps
module display_driver_model (
	input wire core_clk,
	input wire write_strobe_n,
	input wire device_select_n,
	input wire enable_strobe_style,
	output int write_count,
	output int low_width
);
int run = 0;
initial write_count = 0;
initial low_width = 0;
always @(posedge core_clk) begin
	if ((enable_strobe_style ? device_select_n : write_strobe_n) === 1'b0) begin
		run <= run + 1;
	end else if (run != 0) begin
		low_width <= run;
		write_count <= write_count + 1;
		run <= 0;
	end
end
endmodule

// ===== serdes_link_bringup_bench.sv
// Testbench for link bring-up and word timing
`timescale 1ns/1ps
module serdes_link_bringup_bench;
localparam int KO = 16;
logic core_clk = 0, rst_n = 0, power_down_n = 0, role_master = 1, enable_strobe_style = 0;
logic word_valid = 0, host_interrupt_req = 0, shared_pin_in = 1;
logic [2:0] multiplier_select = 3'h0;
logic [15:0] word_data = 16'hA5C3;
logic shared_pin_out, shared_pin_oe_n, serial_data_lane_a_oe_n, serial_link_clock_out;
logic link_ready, word_busy, resync, write_strobe_n, device_select_n, clock_output_enable;
int err_count = 0, samples_checked = 0, wc, lw;
int r[7] = '{2, 4, 6, 7, 8, 9, 10};
serdes_link_bringup #(.KEEP_OFF(KO)) serdes_link_bringup_inst (.core_clk, .rst_n, .power_down_n,
	.role_master, .multiplier_select, .enable_strobe_style, .word_valid, .word_data,
	.host_interrupt_req, .shared_pin_in, .shared_pin_out, .shared_pin_oe_n,
	.serial_data_lane_a_in(1'b0), .serial_data_lane_b_in(1'b0), .serial_data_lane_a_out(),
	.serial_data_lane_b_out(), .serial_data_lane_a_oe_n, .serial_data_lane_b_oe_n(),
	.serial_link_clock_out, .serial_link_clock_oe_n(), .link_ready, .word_busy, .resync,
	.write_strobe_n, .device_select_n, .clock_output_enable);
display_driver_model display_driver_model_inst (.core_clk, .write_strobe_n, .device_select_n,
	.enable_strobe_style, .write_count(wc), .low_width(lw));
always #5 core_clk = ~core_clk;
task check(input logic [31:0] seen, input logic [31:0] exp);
	samples_checked++;
	if (seen !== exp) begin
		err_count++;
		$display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
	end
endtask
task print_verdict;
	if (err_count == 0 && samples_checked > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
task automatic wait_sig(ref logic s, input logic v, output int n);
	for (n = 0; s !== v; n++) begin
		@(negedge core_clk);
		if (n > 900) begin
			err_count++;
			print_verdict;
		end
	end
endtask
task t_bringup;
	int n;
	check({link_ready, write_strobe_n, device_select_n, word_busy}, 4'h7);
	power_down_n = 1;
	wait_sig(link_ready, 1, n);
	check(n >= KO + 41 && n <= KO + 46, 1);
endtask
task t_word(input logic st, input logic [2:0] c, input logic two);
	int n, w, k;
	logic rs;
	enable_strobe_style = st;
	multiplier_select = c;
	@(negedge core_clk);
	w = wc;
	for (k = 0; k <= two; k++) begin
		if (k != 0)
			repeat (6 * r[c] - 1 - n) @(negedge core_clk);
		word_valid = 1;
		wait_sig(word_busy, 0, n);
		wait_sig(word_busy, 1, n);
		word_valid = 0;
		rs = 0;
		for (n = 0; word_busy === 1 && n < 900; n++) begin
			rs |= resync;
			@(negedge core_clk);
		end
		check(rs, k == 0);
		check(n >= 4 * r[c] && n <= 5 * r[c] + 2, 1);
	end
	for (n = 0; wc != w + two + 1 && n < 900; n++)
		@(negedge core_clk);
	check(wc, w + two + 1);
	check(lw, 3 * r[c]);
endtask
task t_rates;
	int c, n, m;
	logic v;
	for (c = 0; c < 7; c++) begin
		multiplier_select = c;
		wait_sig(serial_link_clock_out, 1, n);
		wait_sig(serial_link_clock_out, 0, n);
		wait_sig(serial_link_clock_out, 1, n);
		wait_sig(serial_link_clock_out, 0, n);
		wait_sig(serial_link_clock_out, 1, m);
		check(n + m, 2 * r[c]);
	end
	multiplier_select = 3'h7;
	repeat (4) @(negedge core_clk);
	v = serial_link_clock_out;
	for (n = 0; n < 60; n++) begin
		@(negedge core_clk);
		check(serial_link_clock_out, v);
	end
	multiplier_select = 3'h0;
endtask
task t_roles;
	host_interrupt_req = 1;
	repeat (2) @(negedge core_clk);
	check({shared_pin_oe_n, shared_pin_out, serial_data_lane_a_oe_n, clock_output_enable}, 4'h4);
	power_down_n = 0;
	repeat (6) @(negedge core_clk);
	role_master = 0;
	power_down_n = 1;
	repeat (6) @(negedge core_clk);
	check({shared_pin_oe_n, serial_data_lane_a_oe_n, clock_output_enable, link_ready}, 4'hE);
	shared_pin_in = 0;
	repeat (3) @(negedge core_clk);
	check(clock_output_enable, 0);
endtask
initial begin
	repeat (16) @(negedge core_clk);
	rst_n = 1;
	repeat (4) @(negedge core_clk);
	t_bringup;
	t_word(0, 3'h0, 0);
	t_word(1, 3'h2, 1);
	t_rates;
	t_roles;
	print_verdict;
end
endmodule
